// ==== src/iss_pkg.sv ====
// shared constants and types for the i2c slave stretch pair
package iss_pkg;
   // ****************
   // timing
   // ****************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_QUARTER_NS = 625;
   localparam int QUARTER_CYC =
      (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] QTR_CNT = 8'(QUARTER_CYC);
   localparam logic [7:0] HALF_CNT = 8'(2 * QUARTER_CYC);
   // ****************
   // register map
   // ****************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_BUF = 8'h08;
   localparam logic [7:0] REG_ADDR = 8'h0c;
   localparam int CTRL_SEN = 0;
   localparam int CTRL_TEN = 1;
   localparam int CTRL_CKP = 4;
   localparam int CTRL_OV = 6;
   localparam int STAT_BF = 0;
   localparam int STAT_UA = 1;
   localparam int STAT_RW = 2;
   localparam int STAT_IRQ = 3;
   localparam int STAT_DA = 5;
   localparam int STAT_ACT = 7;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ****************
   // protocol
   // ****************
   localparam logic [4:0] TEN_HDR = 5'h1e;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [1:0] TEN_NONE = 2'h0;
   localparam logic [1:0] TEN_HIGH = 2'h1;
   localparam logic [1:0] TEN_FULL = 2'h2;
   typedef enum logic [1:0] {
      CMD_START, CMD_STOP, CMD_WRITE, CMD_READ
   } iss_cmd_t;
endpackage : iss_pkg

// ==== src/iss_if.sv ====
// open-drain i2c link joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface iss_if;
   logic sclMstOut;
   logic sclMstOe;
   logic sdaMstOut;
   logic sdaMstOe;
   logic sclSlvOut;
   logic sclSlvOe;
   logic sdaSlvOut;
   logic sdaSlvOe;
   wire scl;
   wire sda;
   // wired-and with pull-up: released lines read high
   assign scl = !((sclMstOe && !sclMstOut) || (sclSlvOe && !sclSlvOut));
   assign sda = !((sdaMstOe && !sdaMstOut) || (sdaSlvOe && !sdaSlvOut));
   modport slv (input scl, sda, output sclSlvOut, sclSlvOe, sdaSlvOut,
      sdaSlvOe);
   modport mst (input scl, sda, output sclMstOut, sclMstOe, sdaMstOut,
      sdaMstOe);
endinterface : iss_if
`default_nettype wire

// ==== src/iss_master.sv ====
// i2c bus master end with clock-stretch aware scl generation
`timescale 1ns/1ps
`default_nettype none
module iss_master import iss_pkg::*; (
   // system
   input wire logic clk_sys,
   input wire logic rst_b,
   // link
   iss_if.mst bus,
   // command
   input wire logic cmdValid,
   input wire iss_cmd_t cmd,
   input wire logic [7:0] cmdData,
   input wire logic cmdAckBit,
   // answer
   output logic busy,
   output logic done,
   output logic [7:0] rdData,
   output logic ackSeen
);
   typedef enum {M_IDLE, M_WAIT, M_STA1, M_STA2, M_LOW, M_HIGH,
      M_STO1, M_STO2, M_STO3} iss_mst_t;
   iss_mst_t st_reg, st_next;
   logic [1:0] sclSync_reg, sdaSync_reg;
   logic [7:0] cnt_reg, cnt_next, tx_reg, tx_next, rx_reg, rx_next;
   logic [7:0] rdData_reg, rdData_next;
   logic [3:0] bitCnt_reg, bitCnt_next;
   logic isRead_reg, isRead_next, ackBit_reg, ackBit_next;
   logic sclOe_reg, sclOe_next, sdaOe_reg, sdaOe_next;
   logic busy_reg, busy_next, done_reg, done_next;
   logic ackSeen_reg, ackSeen_next;
   wire sclS = sclSync_reg[1];
   wire sdaS = sdaSync_reg[1];
   wire halfDone = (cnt_reg == HALF_CNT);
   wire [7:0] cntInc = cnt_reg + 8'h01;
   // ****************
   // sequencer
   // ****************
   always_comb begin
      st_next = st_reg;
      cnt_next = cntInc;
      tx_next = tx_reg;
      rx_next = rx_reg;
      rdData_next = rdData_reg;
      bitCnt_next = bitCnt_reg;
      isRead_next = isRead_reg;
      ackBit_next = ackBit_reg;
      sclOe_next = sclOe_reg;
      sdaOe_next = sdaOe_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      ackSeen_next = ackSeen_reg;
      case (st_reg)
         M_IDLE: begin
            cnt_next = BYTE_ZERO;
            if (cmdValid && cmd == CMD_START) begin
               st_next = M_STA1;
               busy_next = 1'b1;
            end
         end
         M_WAIT: begin
            cnt_next = BYTE_ZERO;
            if (cmdValid) begin
               busy_next = 1'b1;
               bitCnt_next = 4'h0;
               tx_next = cmdData;
               isRead_next = (cmd == CMD_READ);
               ackBit_next = cmdAckBit;
               if (cmd == CMD_START) begin
                  st_next = M_STA1;
                  sdaOe_next = 1'b0;
               end else if (cmd == CMD_STOP) begin
                  st_next = M_STO1;
                  sdaOe_next = 1'b1;
               end else begin
                  st_next = M_LOW;
               end
            end
         end
         M_STA1: begin
            sclOe_next = 1'b0;
            // a held scl clears the count: stretching slave wins
            if (!sclS) cnt_next = BYTE_ZERO;
            if (halfDone) begin
               st_next = M_STA2;
               cnt_next = BYTE_ZERO;
               sdaOe_next = 1'b1;
            end
         end
         M_STA2: if (halfDone) begin
            st_next = M_WAIT;
            sclOe_next = 1'b1;
            busy_next = 1'b0;
            done_next = 1'b1;
         end
         M_LOW: begin
            if (cnt_reg == QTR_CNT) begin
               if (bitCnt_reg == BIT_ACK) sdaOe_next = isRead_reg && !ackBit_reg;
               else sdaOe_next = !isRead_reg && !tx_reg[7];
            end
            if (halfDone) begin
               st_next = M_HIGH;
               cnt_next = BYTE_ZERO;
               sclOe_next = 1'b0;
            end
         end
         M_HIGH: begin
            if (!sclS) cnt_next = BYTE_ZERO;
            if (halfDone) begin
               cnt_next = BYTE_ZERO;
               sclOe_next = 1'b1;
               if (bitCnt_reg == BIT_ACK) begin
                  ackSeen_next = !sdaS;
                  rdData_next = rx_reg;
                  st_next = M_WAIT;
                  busy_next = 1'b0;
                  done_next = 1'b1;
               end else begin
                  rx_next = {rx_reg[6:0], sdaS};
                  tx_next = {tx_reg[6:0], 1'b1};
                  bitCnt_next = bitCnt_reg + 4'h1;
                  st_next = M_LOW;
               end
            end
         end
         M_STO1: if (cnt_reg == QTR_CNT) begin
            st_next = M_STO2;
            cnt_next = BYTE_ZERO;
            sclOe_next = 1'b0;
         end
         M_STO2: begin
            if (!sclS) cnt_next = BYTE_ZERO;
            if (halfDone) begin
               st_next = M_STO3;
               cnt_next = BYTE_ZERO;
               sdaOe_next = 1'b0;
            end
         end
         default: if (halfDone) begin
            st_next = M_IDLE;
            busy_next = 1'b0;
            done_next = 1'b1;
         end
      endcase
   end
   // ****************
   // registers
   // ****************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= M_IDLE;
         sclSync_reg <= 2'b11;
         sdaSync_reg <= 2'b11;
         {cnt_reg, tx_reg, rx_reg, rdData_reg} <= '0;
         {bitCnt_reg, isRead_reg, ackBit_reg, ackSeen_reg} <= '0;
         {sclOe_reg, sdaOe_reg, busy_reg, done_reg} <= '0;
      end else begin
         st_reg <= st_next;
         sclSync_reg <= {sclSync_reg[0], bus.scl};
         sdaSync_reg <= {sdaSync_reg[0], bus.sda};
         {cnt_reg, tx_reg, rx_reg, rdData_reg} <=
            {cnt_next, tx_next, rx_next, rdData_next};
         {bitCnt_reg, isRead_reg, ackBit_reg, ackSeen_reg} <=
            {bitCnt_next, isRead_next, ackBit_next, ackSeen_next};
         {sclOe_reg, sdaOe_reg, busy_reg, done_reg} <=
            {sclOe_next, sdaOe_next, busy_next, done_next};
      end
   end
   assign bus.sclMstOut = 1'b0;
   assign bus.sdaMstOut = 1'b0;
   assign bus.sclMstOe = sclOe_reg;
   assign bus.sdaMstOe = sdaOe_reg;
   assign busy = busy_reg;
   assign done = done_reg;
   assign rdData = rdData_reg;
   assign ackSeen = ackSeen_reg;
endmodule : iss_master
`default_nettype wire

// ==== src/iss_slave.sv ====
// i2c slave transfer logic with ack, overflow and clock stretching
// Functional notes
// - write address match: clear rw, load, ack
// - no address ack while buffer full or overflow
// - irq flag per byte, software clears
// - receive stretch holds scl till release bit
// - read address match: set rw, ack, stretch
// - transmit buffer write also loads shifter
// - transmit bits change on scl falling edge
// - master nack at ninth rise resets slave
// - software reloads byte and releases each time
// - transmit irq at ninth falling edge; none after a master nack, slave already idle
// - 7-bit receive: full buffer clears release bit
// - early buffer read prevents the stretch
// - release bit settable regardless of full flag
// - 10-bit address stretch until address rewrite
// - address-update set after both address bytes
// - full-flag stretching only in data bytes
// - transmit: empty buffer clears release bit
// - early buffer load prevents the stretch
// - third 10-bit address: full flag governs
// - drive scl low only once seen low
// - address compared at eighth falling edge
// - buffer read clears full; overflow stays
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module iss_slave import iss_pkg::*; (
   // system
   input wire logic clk_sys,
   input wire logic rst_b,
   // link
   iss_if.slv bus,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata
);
   typedef enum {SL_IDLE, SL_ADDR, SL_RX, SL_TX} iss_slv_t;
   iss_slv_t st_reg, st_next;
   logic [1:0] sclSync_reg, sdaSync_reg;
   logic sclQ_reg, sdaQ_reg;
   logic [3:0] bitCnt_reg, bitCnt_next;
   logic [7:0] shift_reg, shift_next, buf_reg, buf_next;
   logic [7:0] addr_reg, addr_next, rdata_reg, rdata_next;
   logic [1:0] ten_reg, ten_next;
   logic bf_reg, bf_next, ov_reg, ov_next, irq_reg, irq_next;
   logic rw_reg, rw_next, ua_reg, ua_next, da_reg, da_next;
   logic ckp_reg, ckp_next, sen_reg, sen_next, tenEn_reg, tenEn_next;
   logic ackDrv_reg, ackDrv_next, uaHold_reg, uaHold_next;
   logic sclOe_reg, sclOe_next, sdaOe_reg, sdaOe_next;
   logic [7:0] ctrlWord, statWord;
   // ****************
   // edge and condition detect
   // ****************
   wire sclS = sclSync_reg[1];
   wire sdaS = sdaSync_reg[1];
   wire sclRise = sclS && !sclQ_reg;
   wire sclFall = !sclS && sclQ_reg;
   wire busHigh = sclS && sclQ_reg;
   wire startSeen = busHigh && !sdaS && sdaQ_reg;
   wire stopSeen = busHigh && sdaS && !sdaQ_reg;
   // ****************
   // register decode
   // ****************
   wire wrCtrl = regWr && regAddr == REG_CTRL;
   wire wrStat = regWr && regAddr == REG_STATUS;
   wire wrBuf = regWr && regAddr == REG_BUF;
   wire wrAddr = regWr && regAddr == REG_ADDR;
   wire rdBuf = regRd && regAddr == REG_BUF;
   // ****************
   // address match
   // ****************
   wire hit7 = shift_reg[7:1] == addr_reg[7:1];
   wire hiHdr = shift_reg[7:3] == TEN_HDR &&
      shift_reg[2:1] == addr_reg[2:1];
   wire hitLo = shift_reg == addr_reg;
   wire readBit = shift_reg[0];
   wire overflow = bf_reg || ov_reg;
   wire hiWrite = hiHdr && !readBit && ten_reg != TEN_HIGH;
   wire hiRead = hiHdr && readBit && ten_reg == TEN_FULL;
   wire loHit = ten_reg == TEN_HIGH && hitLo;
   wire addrHit = tenEn_reg ? (hiWrite || hiRead || loHit) : hit7;
   // 10-bit high write byte and low byte both need an address rewrite
   wire setUa = tenEn_reg && (hiWrite || loHit);
   wire addrRead = tenEn_reg ? hiRead : readBit;
   wire isData = st_reg != SL_ADDR;
   always_comb begin
      st_next = st_reg;
      bitCnt_next = bitCnt_reg;
      shift_next = shift_reg;
      buf_next = buf_reg;
      addr_next = addr_reg;
      ten_next = ten_reg;
      bf_next = bf_reg;
      ov_next = ov_reg;
      irq_next = irq_reg;
      rw_next = rw_reg;
      ua_next = ua_reg;
      da_next = da_reg;
      ckp_next = ckp_reg;
      sen_next = sen_reg;
      tenEn_next = tenEn_reg;
      ackDrv_next = ackDrv_reg;
      uaHold_next = uaHold_reg;
      // ****************
      // software side, applied first so hardware sets win
      // ****************
      if (wrCtrl) begin
         sen_next = regWdata[CTRL_SEN];
         tenEn_next = regWdata[CTRL_TEN];
         ckp_next = regWdata[CTRL_CKP];
         if (!regWdata[CTRL_OV]) ov_next = 1'b0;
      end else if (wrStat) begin
         if (regWdata[STAT_IRQ]) irq_next = 1'b0;
      end else if (wrBuf && st_reg == SL_TX) begin
         buf_next = regWdata;
         shift_next = regWdata;
         bf_next = 1'b1;
      end else if (wrAddr) begin
         addr_next = regWdata;
         ua_next = 1'b0;
         uaHold_next = 1'b0;
      end
      if (rdBuf) bf_next = 1'b0;
      // ****************
      // bus side
      // ****************
      if (stopSeen) begin
         st_next = SL_IDLE;
         ackDrv_next = 1'b0;
         ten_next = TEN_NONE;
      end else if (startSeen) begin
         st_next = SL_ADDR;
         bitCnt_next = '1; // the start's own scl fall wraps it to zero
         ackDrv_next = 1'b0;
         // a repeated start keeps a completed 10-bit match
         if (ten_reg != TEN_FULL) ten_next = TEN_NONE;
      end else if (st_reg != SL_IDLE && sclRise) begin
         if (bitCnt_reg != BIT_ACK && st_reg != SL_TX) begin
            shift_next = {shift_reg[6:0], sdaS};
         end else if (bitCnt_reg == BIT_ACK && st_reg == SL_TX && sdaS) begin
            st_next = SL_IDLE;
            bf_next = 1'b0;
            rw_next = 1'b0;
            ua_next = 1'b0;
            da_next = 1'b0;
            ten_next = TEN_NONE;
         end
      end else if (st_reg != SL_IDLE && sclFall) begin
         if (bitCnt_reg == BIT_ACK) begin
            bitCnt_next = 4'h0;
            ackDrv_next = 1'b0;
            irq_next = 1'b1;
            if (st_reg == SL_TX && !bf_next) begin
               ckp_next = 1'b0;
            end else if (st_reg == SL_RX && da_reg && sen_reg && bf_next) begin
               ckp_next = 1'b0;
            end
            if (ua_next) uaHold_next = 1'b1;
         end else begin
            bitCnt_next = bitCnt_reg + 4'h1;
            if (st_reg == SL_TX) begin
               shift_next = {shift_reg[6:0], 1'b1};
               // shifter empty: byte done, buffer free again
               if (bitCnt_reg == BIT_LAST) bf_next = 1'b0;
            end
            if (bitCnt_reg == BIT_LAST) begin
               da_next = isData;
               if (st_reg == SL_ADDR) begin
                  if (!addrHit) begin
                     st_next = SL_IDLE;
                     ten_next = TEN_NONE;
                  end else if (!overflow) begin
                     buf_next = shift_reg;
                     // read address leaves full clear so tx stretches
                     bf_next = !addrRead;
                     rw_next = addrRead;
                     ackDrv_next = 1'b1;
                     if (setUa) ua_next = 1'b1;
                     if (tenEn_reg && hiWrite) ten_next = TEN_HIGH;
                     if (loHit) ten_next = TEN_FULL;
                     if (addrRead) st_next = SL_TX;
                     else if (!tenEn_reg || loHit) st_next = SL_RX;
                  end
               end else if (st_reg == SL_RX) begin
                  if (overflow) ov_next = 1'b1;
                  else begin
                     buf_next = shift_reg;
                     bf_next = 1'b1;
                     ackDrv_next = 1'b1;
                  end
               end
            end
         end
      end
   end
   // ****************
   // pin drive
   // ****************
   wire stretchReq = !ckp_next || uaHold_next;
   // never pull scl high-to-low ourselves, keeps the high time intact
   assign sclOe_next = st_next != SL_IDLE && stretchReq &&
      (sclOe_reg || !sclS);
   assign sdaOe_next = ackDrv_next || (st_next == SL_TX &&
      bitCnt_next != BIT_ACK && !shift_next[7]);
   // ****************
   // read mux
   // ****************
   always_comb begin
      ctrlWord = BYTE_ZERO;
      ctrlWord[CTRL_SEN] = sen_reg;
      ctrlWord[CTRL_TEN] = tenEn_reg;
      ctrlWord[CTRL_CKP] = ckp_reg;
      ctrlWord[CTRL_OV] = ov_reg;
      statWord = BYTE_ZERO;
      statWord[STAT_BF] = bf_reg;
      statWord[STAT_UA] = ua_reg;
      statWord[STAT_RW] = rw_reg;
      statWord[STAT_IRQ] = irq_reg;
      statWord[STAT_DA] = da_reg;
      statWord[STAT_ACT] = st_reg != SL_IDLE;
   end
   assign rdata_next = !regRd ? BYTE_ZERO :
      regAddr == REG_CTRL ? ctrlWord :
      regAddr == REG_STATUS ? statWord :
      regAddr == REG_BUF ? buf_reg :
      regAddr == REG_ADDR ? addr_reg : BYTE_ZERO;
   // ****************
   // registers
   // ****************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclSync_reg <= 2'b11;
         sdaSync_reg <= 2'b11;
         sclQ_reg <= 1'b1;
         sdaQ_reg <= 1'b1;
      end else begin
         sclSync_reg <= {sclSync_reg[0], bus.scl};
         sdaSync_reg <= {sdaSync_reg[0], bus.sda};
         sclQ_reg <= sclS;
         sdaQ_reg <= sdaS;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= SL_IDLE;
         {bitCnt_reg, ten_reg} <= '0;
         {shift_reg, buf_reg, rdata_reg} <= '0;
         addr_reg <= ADDR_RST;
         {bf_reg, ov_reg, irq_reg, rw_reg, ua_reg, da_reg} <= '0;
         {ckp_reg, sen_reg, tenEn_reg} <= 3'b100;
         {ackDrv_reg, uaHold_reg, sclOe_reg, sdaOe_reg} <= '0;
      end else begin
         st_reg <= st_next;
         {bitCnt_reg, ten_reg} <= {bitCnt_next, ten_next};
         {shift_reg, buf_reg, rdata_reg} <=
            {shift_next, buf_next, rdata_next};
         addr_reg <= addr_next;
         {bf_reg, ov_reg, irq_reg, rw_reg, ua_reg, da_reg} <=
            {bf_next, ov_next, irq_next, rw_next, ua_next, da_next};
         {ckp_reg, sen_reg, tenEn_reg} <= {ckp_next, sen_next, tenEn_next};
         {ackDrv_reg, uaHold_reg, sclOe_reg, sdaOe_reg} <=
            {ackDrv_next, uaHold_next, sclOe_next, sdaOe_next};
      end
   end
   assign bus.sclSlvOut = 1'b0;
   assign bus.sdaSlvOut = 1'b0;
   assign bus.sclSlvOe = sclOe_reg;
   assign bus.sdaSlvOe = sdaOe_reg;
   assign regRdata = rdata_reg;
endmodule : iss_slave
`default_nettype wire

// ==== sim/iss_asserts.sv ====
// link checks between master and slave ends
`timescale 1ns/1ps
`default_nettype none
module iss_asserts (
   // system
   input wire logic clk_sys,
   input wire logic rst_b,
   // master drive
   input wire logic sclMstOut,
   input wire logic sclMstOe,
   input wire logic sdaMstOut,
   input wire logic sdaMstOe,
   // slave drive
   input wire logic sclSlvOut,
   input wire logic sclSlvOe,
   input wire logic sdaSlvOut,
   input wire logic sdaSlvOe,
   // wires
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // ****
   // sequences
   // ****
   sequence sclLowHold;
      !scl [*8];
   endsequence
   sequence ackHold;
      (sdaSlvOe && !scl) [*8];
   endsequence
   // ****
   // checks
   // ****
   stretch_seen_low_a: assert property (
      $rose(sclSlvOe) |-> !$past(scl) && !$past(scl, 2))
      else $error("slave pulled scl while high");
   stretch_master_low_a: assert property (
      $rose(sclSlvOe) |-> sclMstOe)
      else $error("stretch began without master low");
   ack_hold_a: assert property (
      $rose(sdaSlvOe) |-> ackHold)
      else $error("slave sda drive too short");
   sda_low_change_a: assert property (
      $changed(sdaSlvOe) |-> !scl)
      else $error("slave sda moved while scl high");
   sda_high_stable_a: assert property (
      $rose(scl) |-> $stable(sdaSlvOe) [*8])
      else $error("slave sda unstable in high phase");
   sync_delay_a: assert property (
      $changed(sdaSlvOe) |-> !$past(scl, 2))
      else $error("slave reacted before sync delay");
   scl_high_min_a: assert property (
      $rose(scl) |-> scl [*8])
      else $error("scl high phase cut short");
   scl_low_min_a: assert property (
      $fell(scl) |-> sclLowHold)
      else $error("scl low phase cut short");
   open_drain_a: assert property (
      !(sclSlvOut || sdaSlvOut || sclMstOut || sdaMstOut))
      else $error("open drain output driven high");
endmodule : iss_asserts
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the i2c slave stretch pair
`timescale 1ns/1ps
`default_nettype none
module tb_top import iss_pkg::*;;
   logic clk_sys, rst_b, cmdValid, cmdAckBit, regWr, regRd;
   logic busy, done, ackSeen;
   iss_cmd_t cmd;
   logic [7:0] cmdData, regAddr, regWdata, regRdata, rdData, d;
   logic [7:0] q[$];
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   iss_if bus();
   iss_master i_iss_master(.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus),
      .cmdValid(cmdValid), .cmd(cmd), .cmdData(cmdData),
      .cmdAckBit(cmdAckBit), .busy(busy), .done(done), .rdData(rdData),
      .ackSeen(ackSeen));
   iss_slave i_iss_slave(.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata));
   iss_asserts i_iss_asserts(.clk_sys(clk_sys), .rst_b(rst_b),
      .sclMstOut(bus.sclMstOut), .sclMstOe(bus.sclMstOe),
      .sdaMstOut(bus.sdaMstOut), .sdaMstOe(bus.sdaMstOe),
      .sclSlvOut(bus.sclSlvOut), .sclSlvOe(bus.sclSlvOe),
      .sdaSlvOut(bus.sdaSlvOut), .sdaSlvOe(bus.sdaSlvOe),
      .scl(bus.scl), .sda(bus.sda));
   // ****
   // tasks
   // ****
   task automatic stop_test;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic chkByte(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chkByte
   task automatic chkBit(input string n, input logic e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask : chkBit
   task automatic wr(input logic [7:0] a, v);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, m, e, input string n);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      chkByte(n, e, regRdata & m);
   endtask : rd
   task automatic go(input iss_cmd_t c, input logic [7:0] v, input logic k);
      @(posedge clk_sys);
      cmdValid <= 1'b1;
      cmd <= c;
      cmdData <= v;
      cmdAckBit <= k;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
   endtask : go
   task automatic fin;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 20000) begin
         fails++;
         stop_test();
      end
      // lets irq and stretch land before register reads
      repeat (12) @(posedge clk_sys);
   endtask : fin
   task automatic mc(input iss_cmd_t c, input logic [7:0] v, input logic k);
      go(c, v, k);
      fin();
   endtask : mc
   // ****
   // clock and watchdog
   // ****
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         stop_test();
      end
   end
   // ****
   // sequence
   // ****
   initial begin
      rst_b = 1'b0;
      cmdValid = 1'b0;
      cmd = CMD_START;
      cmdData = 8'h00;
      cmdAckBit = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      void'($urandom(32'hbf8f));
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(REG_CTRL, 8'hff, 8'h10, "ctrl");
      rd(REG_ADDR, 8'hff, ADDR_RST, "addr");
      rd(8'h10, 8'hff, 8'h00, "unmapped");
      wr(REG_ADDR, 8'h54);
      wr(REG_CTRL, 8'h11);
      mc(CMD_START, 8'h00, 1'b0);
      mc(CMD_WRITE, 8'h56, 1'b0);
      chkBit("ack", 1'b0, ackSeen);
      mc(CMD_STOP, 8'h00, 1'b0);
      mc(CMD_START, 8'h00, 1'b0);
      mc(CMD_WRITE, 8'h54, 1'b0);
      chkBit("ack", 1'b1, ackSeen);
      rd(REG_STATUS, 8'h0d, 8'h09, "status");
      rd(REG_CTRL, 8'hff, 8'h11, "ctrl");
      rd(REG_BUF, 8'hff, 8'h54, "buf");
      wr(REG_STATUS, 8'h08);
      rd(REG_STATUS, 8'h09, 8'h00, "status");
      d = 8'($urandom);
      q.push_back(d);
      mc(CMD_WRITE, d, 1'b0);
      rd(REG_CTRL, 8'hff, 8'h01, "ctrl");
      rd(REG_STATUS, 8'h09, 8'h09, "status");
      d = 8'($urandom);
      q.push_back(d);
      go(CMD_WRITE, d, 1'b0);
      repeat (400) @(posedge clk_sys);
      #1;
      chkBit("busy", 1'b1, busy);
      rd(REG_BUF, 8'hff, q.pop_front(), "buf");
      wr(REG_CTRL, 8'h11);
      fin();
      chkBit("ack", 1'b1, ackSeen);
      // release without read: next byte overflows
      wr(REG_CTRL, 8'h11);
      mc(CMD_WRITE, 8'($urandom), 1'b0);
      chkBit("ack", 1'b0, ackSeen);
      rd(REG_CTRL, 8'hff, 8'h41, "ctrl");
      rd(REG_BUF, 8'hff, q.pop_front(), "buf");
      rd(REG_CTRL, 8'h40, 8'h40, "ctrl");
      wr(REG_CTRL, 8'h11);
      rd(REG_CTRL, 8'hff, 8'h11, "ctrl");
      mc(CMD_STOP, 8'h00, 1'b0);
      mc(CMD_START, 8'h00, 1'b0);
      mc(CMD_WRITE, 8'h54, 1'b0);
      mc(CMD_STOP, 8'h00, 1'b0);
      mc(CMD_START, 8'h00, 1'b0);
      mc(CMD_WRITE, 8'h54, 1'b0);
      chkBit("ack", 1'b0, ackSeen);
      rd(REG_BUF, 8'hff, 8'h54, "buf");
      mc(CMD_STOP, 8'h00, 1'b0);
      mc(CMD_START, 8'h00, 1'b0);
      mc(CMD_WRITE, 8'h55, 1'b0);
      chkBit("ack", 1'b1, ackSeen);
      rd(REG_STATUS, 8'h05, 8'h04, "status");
      rd(REG_CTRL, 8'h10, 8'h00, "ctrl");
      wr(REG_STATUS, 8'h08);
      for (int i = 0; i < 2; i++) begin
         d = 8'($urandom);
         wr(REG_BUF, d);
         wr(REG_CTRL, 8'h10);
         mc(CMD_READ, 8'h00, 1'(i));
         chkByte("rdData", d, rdData);
         if (i == 0) begin
            rd(REG_CTRL, 8'hff, 8'h00, "ctrl");
            rd(REG_STATUS, 8'h08, 8'h08, "status");
         end
      end
      rd(REG_STATUS, 8'h05, 8'h00, "status");
      mc(CMD_STOP, 8'h00, 1'b0);
      // 10-bit receive: both address bytes stretch on the update flag
      wr(REG_CTRL, 8'h13);
      wr(REG_ADDR, 8'h02);
      mc(CMD_START, 8'h00, 1'b0);
      mc(CMD_WRITE, 8'hf2, 1'b0);
      chkBit("ack", 1'b1, ackSeen);
      rd(REG_STATUS, 8'h07, 8'h03, "status");
      rd(REG_CTRL, 8'h10, 8'h10, "ctrl");
      rd(REG_BUF, 8'hff, 8'hf2, "buf");
      go(CMD_WRITE, 8'h5a, 1'b0);
      repeat (400) @(posedge clk_sys);
      #1;
      chkBit("busy", 1'b1, busy);
      wr(REG_ADDR, 8'h5a);
      fin();
      chkBit("ack", 1'b1, ackSeen);
      rd(REG_STATUS, 8'h07, 8'h03, "status");
      rd(REG_BUF, 8'hff, 8'h5a, "buf");
      wr(REG_ADDR, 8'h02);
      d = 8'($urandom);
      q.push_back(d);
      mc(CMD_WRITE, d, 1'b0);
      chkBit("ack", 1'b1, ackSeen);
      rd(REG_CTRL, 8'hff, 8'h03, "ctrl");
      rd(REG_BUF, 8'hff, q.pop_front(), "buf");
      wr(REG_CTRL, 8'h13);
      mc(CMD_STOP, 8'h00, 1'b0);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
